//--- verilog/ecache_write_read_scheduler.sv
// scheduler of tag and data SRAM accesses for the external second-level cache
`timescale 1ns/1ps
module ecache_write_read_scheduler
  import ecache_sched_pkg::*;
(
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           resetn,
  // mode straps
  input  wire logic                           div3_select,
  input  wire logic                           sram_test,
  output logic                                system_clock,
  // load port
  input  wire logic                           load_valid,
  input  ecache_sched_pkg::load_req_t         load_req,
  output logic                                load_ready,
  output logic                                load_data_valid,
  output logic [ecache_sched_pkg::DATA_W-1:0] load_data,
  // store port
  input  wire logic                           store_valid,
  input  ecache_sched_pkg::store_req_t        store_req,
  output logic                                store_ready,
  // coherence engine: ownership read and miss refill
  output logic                                own_req,
  output logic                                fill_req,
  output logic [ecache_sched_pkg::PA_W-1:0]   coh_addr,
  input  wire logic                           coh_done,
  // tag SRAM
  output logic [ecache_sched_pkg::TADDR_W-1:0] tag_ram_address,
  output logic                                tag_write_enable_n,
  output logic                                tag_output_enable_n,
  input  ecache_sched_pkg::tag_word_t         tag_in,
  output ecache_sched_pkg::tag_word_t         tag_out,
  output logic                                tag_oe,
  // data SRAM
  output logic [ecache_sched_pkg::DADDR_W-1:0] data_ram_address,
  output logic                                data_write_enable_n,
  output logic                                data_output_enable_n,
  output logic [ecache_sched_pkg::BYTES-1:0]  byte_write_enable_n,
  input  wire logic [ecache_sched_pkg::DATA_W-1:0] data_in,
  output logic [ecache_sched_pkg::DATA_W-1:0] data_out,
  output logic                                data_oe
);
  import ecache_sched_pkg::*;

  // ***************************************************************
  // store tag pipeline
  // ***************************************************************
  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_WAIT = 2'b01,
    P_COH  = 2'b11
  } pend_t;

  // a lookup's tag returns RD_RET cycles after its address; carried down a pipe
  logic [RD_RET:0] tlk_v_q;
  store_req_t      tlk_s_q [RD_RET+1];
  logic            ld_v_q [RD_RET+1];
  logic            wq_v_q;          // one store ready to write data
  store_req_t      wq_q;
  logic            wq_upd_q;        // exclusive line: tag update with data write
  pend_t           pend_q;
  store_req_t      pend_s_q;

  logic tag_rd_go, tag_wr_go, data_rd_go, data_wr_go;
  logic tag_wr_ok, data_wr_ok;
  logic resolve;
  logic hit_em, hit_so, miss;
  tag_word_t rtag;

  assign rtag    = tag_in;
  assign resolve = tlk_v_q[RD_RET];
  assign hit_em  = resolve && (rtag.tag == tlk_s_q[RD_RET].addr[PA_W-1:TADDR_LO-3])
                   && (rtag.state == ST_EXCLUSIVE || rtag.state == ST_MODIFIED);
  assign hit_so  = resolve && (rtag.tag == tlk_s_q[RD_RET].addr[PA_W-1:TADDR_LO-3])
                   && (rtag.state == ST_SHARED || rtag.state == ST_OWNED);
  assign miss    = resolve && !hit_em && !hit_so;

  // ***************************************************************
  // issue arbitration
  // ***************************************************************
  // loads first; loads never wait for writes, but a store tag lookup waits for a tag write
  assign data_rd_go = load_valid;
  assign load_ready = 1'b1;
  // a data write needs the pending store and a clear bus
  assign data_wr_go = wq_v_q && data_wr_ok && (tag_wr_ok || !wq_upd_q) && !data_rd_go;
  // tag update only for exclusive lines, in the same cycle as the data write
  assign tag_wr_go  = data_wr_go && wq_upd_q;
  // modified-line writes leave the tag bus for the next lookup; one lookup in flight
  // keeps the single write slot from being overwritten, and the next lookup still
  // overlaps the data write of the store ahead of it
  assign tag_rd_go  = store_valid && !tag_wr_go && pend_q == P_IDLE
                      && (tlk_v_q == '0) && (!wq_v_q || data_wr_go);
  assign store_ready = tag_rd_go;

  bus_turn_guard #(.GAP(RW_GAP)) u_tag_guard (
    .clk      (clk),
    .resetn   (resetn),
    .rd_issue (tag_rd_go),
    .wr_issue (tag_wr_go),
    .wr_ok    (tag_wr_ok)
  );

  bus_turn_guard #(.GAP(RW_GAP)) u_data_guard (
    .clk      (clk),
    .resetn   (resetn),
    .rd_issue (data_rd_go),
    .wr_issue (data_wr_go),
    .wr_ok    (data_wr_ok)
  );

  // tag gap is folded into the data write decision so both buses keep it
  logic wr_both_ok;
  assign wr_both_ok = tag_wr_ok || !wq_upd_q;

  // ***************************************************************
  // lookup pipeline
  // ***************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tlk_v_q <= '0;
    end else begin
      tlk_v_q <= {tlk_v_q[RD_RET-1:0], tag_rd_go};
    end
  end

  always_ff @(posedge clk) begin
    tlk_s_q[0] <= store_req;
    for (int i = 1; i <= RD_RET; i++) begin
      tlk_s_q[i] <= tlk_s_q[i-1];
    end
  end

  // load return pipe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i <= RD_RET; i++) begin
        ld_v_q[i] <= 1'b0;
      end
    end else begin
      ld_v_q[0] <= data_rd_go;
      for (int i = 1; i <= RD_RET; i++) begin
        ld_v_q[i] <= ld_v_q[i-1];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      load_data_valid <= 1'b0;
      load_data       <= '0;
    end else begin
      load_data_valid <= ld_v_q[RD_RET];
      load_data       <= data_in;
    end
  end

  // ***************************************************************
  // write queue and coherence wait
  // ***************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wq_v_q   <= 1'b0;
      wq_q     <= '0;
      wq_upd_q <= 1'b0;
      pend_q   <= P_IDLE;
      pend_s_q <= '0;
    end else begin
      if (data_wr_go && wr_both_ok) begin
        wq_v_q <= 1'b0;
      end
      if (hit_em) begin
        wq_v_q   <= 1'b1;
        wq_q     <= tlk_s_q[RD_RET];
        wq_upd_q <= (rtag.state == ST_EXCLUSIVE);
      end else if (pend_q == P_WAIT && coh_done) begin
        wq_v_q   <= 1'b1;
        wq_q     <= pend_s_q;
        wq_upd_q <= 1'b0;
      end
      unique case (pend_q)
        P_IDLE: begin
          if (hit_so || miss) begin
            pend_q   <= P_COH;
            pend_s_q <= tlk_s_q[RD_RET];
          end
        end
        P_COH:  pend_q <= P_WAIT;
        P_WAIT: begin
          if (coh_done) begin
            pend_q <= P_IDLE;
          end
        end
        default: pend_q <= P_IDLE;
      endcase
    end
  end

  // coherence requests: ownership read or victim plus refill
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      own_req  <= 1'b0;
      fill_req <= 1'b0;
      coh_addr <= '0;
    end else begin
      own_req  <= hit_so;
      fill_req <= miss;
      if (hit_so || miss) begin
        coh_addr <= tlk_s_q[RD_RET].addr;
      end
    end
  end

  // ***************************************************************
  // SRAM pins
  // ***************************************************************
  logic            wdata_pend_q;
  logic [DATA_W-1:0] wdata_q;

  // address and controls registered off the issue decision
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tag_ram_address      <= '0;
      tag_write_enable_n   <= 1'b1;
      tag_output_enable_n  <= 1'b1;
      tag_out              <= '0;
      data_ram_address     <= '0;
      data_write_enable_n  <= 1'b1;
      data_output_enable_n <= 1'b1;
      byte_write_enable_n  <= '1;
      wdata_pend_q         <= 1'b0;
      wdata_q              <= '0;
      data_out             <= '0;
    end else begin
      tag_write_enable_n  <= !tag_wr_go;
      tag_output_enable_n <= !(tag_rd_go || tag_wr_go);
      if (tag_rd_go) begin
        tag_ram_address <= store_req.addr[PA_W-1:TADDR_LO];
      end else if (tag_wr_go) begin
        tag_ram_address <= wq_q.addr[PA_W-1:TADDR_LO];
        tag_out         <= '{tag: wq_q.addr[PA_W-1:TADDR_LO-3], state: ST_MODIFIED};
      end
      data_write_enable_n  <= !data_wr_go;
      data_output_enable_n <= !(data_rd_go || data_wr_go);
      byte_write_enable_n  <= data_wr_go ? ~wq_q.bytes : '1;
      if (data_rd_go) begin
        data_ram_address <= load_req.addr[PA_W-1:DADDR_LO];
      end else if (data_wr_go) begin
        data_ram_address <= wq_q.addr[PA_W-1:DADDR_LO];
      end
      wdata_pend_q <= !data_write_enable_n;
      wdata_q      <= wq_q.data;
      data_out     <= wdata_q;
    end
  end

  // data follows the write address by one cycle; tag data with its address
  logic tag_oe_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tag_oe_q <= 1'b0;
    end else begin
      tag_oe_q <= tag_wr_go;
    end
  end

  // bidirectional buses float under reset with sram test
  assign data_oe = wdata_pend_q && !(sram_test && !resetn);
  assign tag_oe  = tag_oe_q && !(sram_test && !resetn);

  // ***************************************************************
  // system clock divider
  // ***************************************************************
  logic [1:0] div_cnt_q;
  logic       div3_q;

  // divider select registered every cycle, so the ratio follows div3_select mid-run
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_q    <= '0;
      div3_q       <= 1'b0;
      system_clock <= 1'b0;
    end else begin
      div3_q <= div3_select;
      if (div_cnt_q == (div3_q ? 2'(DIV3_RATIO - 1) : 2'(DIV2_RATIO - 1))) begin
        div_cnt_q <= '0;
      end else begin
        div_cnt_q <= div_cnt_q + 2'd1;
      end
      system_clock <= (div_cnt_q == 2'd0);
    end
  end

  // reset is taken asynchronously; release timing is the system's duty

  // ***************************************************************
  // assertions
  // ***************************************************************
  a_wdata_follows: assert property (@(posedge clk) disable iff (!resetn)
    data_wr_go |=> ##1 data_oe) else $error("write data not one cycle after address");
  a_excl_tag_upd: assert property (@(posedge clk) disable iff (!resetn)
    (data_wr_go && wq_upd_q) |=> !tag_write_enable_n) else $error("missing tag update");
  a_mod_tag_free: assert property (@(posedge clk) disable iff (!resetn)
    (data_wr_go && !wq_upd_q) |=> tag_write_enable_n) else $error("tag bus taken on modified write");
  a_read_no_wait: assert property (@(posedge clk) disable iff (!resetn)
    load_valid |=> !data_output_enable_n) else $error("read delayed");
  a_so_owns_first: assert property (@(posedge clk) disable iff (!resetn)
    hit_so |=> own_req) else $error("no ownership read");
  a_miss_fills: assert property (@(posedge clk) disable iff (!resetn)
    miss |=> fill_req ##1 (pend_q == P_WAIT)) else $error("miss not refilled");
  a_load_ret: assert property (@(posedge clk) disable iff (!resetn)
    data_rd_go |-> ##4 load_data_valid) else $error("load return time wrong");
  a_write_on_hit: assert property (@(posedge clk) disable iff (!resetn)
    hit_em |=> wq_v_q) else $error("hit store not queued for write");

endmodule

//--- include/ecache_sched_pkg.sv
// constants and carrier types for the second-level cache write/read scheduler
// ****************************************************************************
// Overview of operation
// - store hit to exclusive line rewrites tag to modified alongside data write
// - store hit to modified line leaves tag bus free during data write
// - tag lookup of next store overlaps data write of previous store
// - store hit to shared or owned line needs ownership read before data write
// - store miss evicts a victim; data written only after refill
// - cache read returns data two cycles after its address
// - write data follows write address by one cycle; SRAM buffers address; tag writes here drive tag data with the address
// - at least two idle cycles between last read and first write address
// - read after write issues next cycle with no idle gap
// - read-to-write gap kept separately on tag and data buses
// - reset asserts asynchronously, released synchronously by the system
// - system clock is two or three processor clocks by divider select
// - bidirectional pins released under reset plus sram test; outputs always driven
// - every store reads tag first; data written on exclusive/modified hit, otherwise after coh_done
// - sixteen active-low byte enables; bit 0 is data bits 127:120
// - data address from physical bits 21:4, tag address from 21:6
// - hitting reads issue back to back, one per cycle
// ****************************************************************************
package ecache_sched_pkg;

  localparam int PA_W        = 22;
  localparam int DADDR_LO    = 4;    // data address starts at physical bit 4
  localparam int TADDR_LO    = 6;    // tag address starts at physical bit 6
  localparam int DADDR_W     = 18;
  localparam int TADDR_W     = 16;
  localparam int DATA_W      = 128;
  localparam int BYTES       = 16;
  localparam int TAG_W       = 22;   // stored tag: physical bits 21:? plus state
  localparam int RD_RET      = 2;    // cycles from read address to bus busy
  localparam int RW_GAP      = 2;    // idle cycles from read to write
  localparam int DIV2_RATIO  = 2;
  localparam int DIV3_RATIO  = 3;

  // line states held in the low bits of a tag word
  typedef enum logic [2:0] {
    ST_INVALID   = 3'h0,
    ST_SHARED    = 3'h1,
    ST_EXCLUSIVE = 3'h2,
    ST_OWNED     = 3'h3,
    ST_MODIFIED  = 3'h4
  } line_state_t;

  // store request from the store buffer
  typedef struct packed {
    logic [PA_W-1:0]   addr;
    logic [DATA_W-1:0] data;
    logic [BYTES-1:0]  bytes;  // bit 0 = data bits 127:120
  } store_req_t;

  // load request from the core
  typedef struct packed {
    logic [PA_W-1:0] addr;
  } load_req_t;

  // tag word as kept in the tag SRAM
  typedef struct packed {
    logic [TAG_W-4:0] tag;
    line_state_t      state;
  } tag_word_t;

endpackage

//--- verilog/bus_turn_guard.sv
// per-bus read-return record and turnaround gap tracker
`timescale 1ns/1ps
module bus_turn_guard #(
  parameter int GAP = 2
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // bus activity this cycle
  input  wire logic rd_issue,
  input  wire logic wr_issue,
  // write may go this cycle
  output logic      wr_ok
);

  // shift record of cycles since the last read address; bit i set = read i+1 ago
  logic [GAP-1:0] hist_q;

  // tracks outstanding read returns so a write never meets read data on the bus
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hist_q <= '0;
    end else begin
      hist_q <= {hist_q[GAP-2:0], rd_issue};
    end
  end

  // a write needs GAP idle cycles after any read; reads never wait on writes
  assign wr_ok = ~(|hist_q);

  a_gap_after_read: assert property (@(posedge clk) disable iff (!resetn)
    rd_issue |=> !wr_issue [*2]) else $error("write issued inside turnaround gap");

endmodule

//--- testbench/ecache_sram_model.sv
// behavioural model of the tag and data pipelined cache SRAMs
`timescale 1ns/1ps
module ecache_sram_model
  import ecache_sched_pkg::*;
(
  // clock
  input  wire logic               clk,
  // tag side
  input  wire logic [TADDR_W-1:0] tag_ram_address,
  input  wire logic               tag_write_enable_n,
  input  wire logic               tag_output_enable_n,
  input  tag_word_t               tag_out,
  input  wire logic               tag_oe,
  output tag_word_t               tag_in,
  // data side
  input  wire logic [DADDR_W-1:0] data_ram_address,
  input  wire logic               data_write_enable_n,
  input  wire logic               data_output_enable_n,
  input  wire logic [BYTES-1:0]   byte_write_enable_n,
  input  wire logic [DATA_W-1:0]  data_out,
  input  wire logic               data_oe,
  output logic [DATA_W-1:0]       data_in
);
  logic [DATA_W-1:0]  dmem [0:(1<<DADDR_W)-1];
  tag_word_t          tmem [0:(1<<TADDR_W)-1];
  logic [DATA_W-1:0]  dq, dl = '0;
  tag_word_t          tq, tl = '0;
  logic [DADDR_W-1:0] da, dw;
  logic [TADDR_W-1:0] ta, tw;
  logic [BYTES-1:0]   bw;
  logic               dr1 = 1'b0, dr2 = 1'b0, tr1 = 1'b0, tr2 = 1'b0, tp = 1'b0;

  // a released bus shows the inverse of its last value, so stale reads cannot pass
  assign data_in = dr2 ? dq : ~dl;
  assign tag_in  = tr2 ? tq : ~tl;

  // two-stage read pipe: data at the pins two cycles after the address
  always @(posedge clk) begin
    dr1 <= !data_output_enable_n && data_write_enable_n;
    tr1 <= !tag_output_enable_n && tag_write_enable_n;
    da  <= data_ram_address;
    ta  <= tag_ram_address;
    dr2 <= dr1;
    tr2 <= tr1;
    dq  <= dmem[da];
    tq  <= tmem[ta];
    dl  <= data_in;
    tl  <= tag_in;
  end

  // late write: address and byte enables wait one cycle in a one-deep buffer
  always @(posedge clk) begin
    if (!data_write_enable_n) begin
      dw <= data_ram_address;
      bw <= byte_write_enable_n;
    end
    if (data_oe)
      for (int b = 0; b < BYTES; b++)
        if (!bw[b]) dmem[dw][DATA_W-1-8*b -: 8] <= data_out[DATA_W-1-8*b -: 8];
    if (!tag_write_enable_n) tw <= tag_ram_address;
    tp <= !tag_write_enable_n && !tag_oe;
    if (tag_oe) tmem[tp ? tw : tag_ram_address] <= tag_out;
  end
endmodule

//--- testbench/ecache_write_read_scheduler_tb_top.sv
// self-checking bench for the cache write/read scheduler
`timescale 1ns/1ps
module ecache_write_read_scheduler_tb_top;
  import ecache_sched_pkg::*;
  logic                    clk, resetn, div3_select, sram_test, system_clock;
  logic                    load_valid, load_ready, load_data_valid, own_req, fill_req;
  logic                    store_valid, store_ready, tag_oe, data_oe, coh_done = 1'b0;
  logic                    tag_write_enable_n, tag_output_enable_n;
  logic                    data_write_enable_n, data_output_enable_n;
  load_req_t               load_req;
  store_req_t              store_req;
  tag_word_t               tag_in, tag_out;
  logic [PA_W-1:0]         coh_addr, ld_a, adr [0:6];
  logic [TADDR_W-1:0]      tag_ram_address;
  logic [DADDR_W-1:0]      data_ram_address;
  logic [BYTES-1:0]        byte_write_enable_n;
  logic [DATA_W-1:0]       load_data, data_in, data_out, wdat, ref_d [0:6];
  logic [DATA_W+BYTES-1:0] wq [$];
  logic [DATA_W-1:0]       lq [$];
  logic [15:0]             seed = 16'h8112; // lfsr start value 33042
  logic                    ld_q = 1'b0, wpend = 1'b0, kq, own_done = 1'b0, fill_done = 1'b0;
  int                      n_errors, samples_checked, cyc, n_ovl, cd;
  int                      last_drd = -10, last_trd = -10;

  ecache_write_read_scheduler i_ecache_write_read_scheduler (.clk, .resetn, .div3_select,
    .sram_test, .system_clock, .load_valid, .load_req, .load_ready, .load_data_valid,
    .load_data, .store_valid, .store_req, .store_ready, .own_req, .fill_req, .coh_addr,
    .coh_done, .tag_ram_address, .tag_write_enable_n, .tag_output_enable_n, .tag_in,
    .tag_out, .tag_oe, .data_ram_address, .data_write_enable_n, .data_output_enable_n,
    .byte_write_enable_n, .data_in, .data_out, .data_oe);
  ecache_sram_model i_ecache_sram_model (.clk, .tag_ram_address, .tag_write_enable_n,
    .tag_output_enable_n, .tag_out, .tag_oe, .tag_in, .data_ram_address,
    .data_write_enable_n, .data_output_enable_n, .byte_write_enable_n, .data_out,
    .data_oe, .data_in);

  task automatic check(input string nm, input logic [DATA_W-1:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // 16-bit lfsr, taps 16 14 13 11
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  // a load is taken on the edge that follows, load_ready being always high
  task automatic load(input int i);
    store_valid <= 1'b0;
    load_valid  <= 1'b1;
    load_req    <= '{addr: adr[i]};
    lq.push_back(ref_d[i]);
    @(posedge clk);
  endtask

  // store held until store_ready, checked mid-cycle where it is settled
  task automatic store(input int i);
    logic [DATA_W-1:0] d;
    logic [BYTES-1:0]  b;
    int                k;
    for (k = 0; k < 8; k++) d = {d[DATA_W-17:0], rnd()};
    b = rnd();
    for (k = 0; k < BYTES; k++) if (b[k]) ref_d[i][DATA_W-1-8*k -: 8] = d[DATA_W-1-8*k -: 8];
    wq.push_back({d, ~b});
    load_valid  <= 1'b0;
    store_valid <= 1'b1;
    store_req   <= '{addr: adr[i], data: d, bytes: b};
    k = 0;
    @(negedge clk);
    while (k < 60 && store_ready !== 1'b1) begin
      @(negedge clk);
      k++;
    end
    if (k == 60) check("store_ready", 0, 1);
    @(posedge clk);
  endtask

  task automatic drain();
    int k;
    for (k = 0; k < 300 && (wq.size() > 0 || lq.size() > 0); k++) @(posedge clk);
    if (k == 300) check("drain", 0, 1);
    repeat (4) @(posedge clk);
  endtask

  // 12 cycles hold 6 or 4 whole system clock periods
  task automatic sysclk(input logic d3);
    int n;
    n = 0;
    div3_select <= d3;
    repeat (7) @(posedge clk);
    repeat (12) begin
      @(negedge clk);
      n += (system_clock === 1'b1);
    end
    check("sysclk", n, d3 ? 4 : 6);
    @(posedge clk);
  endtask

  // coherence stand-in: marks the line exclusive at the request, then answers slowly
  always @(posedge clk) begin
    coh_done <= (cd == 1);
    if (cd > 0) cd <= cd - 1;
    if (cd == 1 && kq) fill_done <= 1'b1;
    if (cd == 1 && !kq) own_done <= 1'b1;
    if (own_req === 1'b1 || fill_req === 1'b1) begin
      check("coh_addr", coh_addr[21:6], adr[fill_req ? 5 : 4][21:6]);
      i_ecache_sram_model.tmem[coh_addr[21:6]] <= '{coh_addr[21:3], ST_EXCLUSIVE};
      kq <= fill_req;
      cd <= 4;
    end
  end

  // pin watcher: takes the oldest note off a queue whenever a result appears
  always @(posedge clk) if (resetn === 1'b1) begin
    logic [BYTES-1:0] ben;
    logic             trd, drd;
    trd = !tag_output_enable_n && tag_write_enable_n;
    drd = !data_output_enable_n && data_write_enable_n;
    cyc <= cyc + 1;
    if (load_data_valid === 1'b1) check("load_data", load_data, lq.pop_front());
    ld_q <= load_valid;
    ld_a <= load_req.addr;
    if (ld_q) check("rd_pins", {drd, data_ram_address}, {1'b1, ld_a[21:4]});
    if (drd) last_drd <= cyc;
    if (trd) last_trd <= cyc;
    if (tag_write_enable_n === 1'b0) check("tag_gap", cyc - last_trd > 2, 1);
    if (trd && data_write_enable_n === 1'b0) n_ovl <= n_ovl + 1;
    wpend <= (data_write_enable_n === 1'b0);
    if (wpend) check("wr_data", {data_oe, data_out}, {1'b1, wdat});
    if (data_write_enable_n === 1'b0) begin
      {wdat, ben} = wq.pop_front();
      check("wr_gap", cyc - last_drd > 2, 1);
      check("byte_en", byte_write_enable_n, ben);
      for (int j = 0; j < 6; j++) if (data_ram_address === adr[j][21:4]) begin
        if (j < 3) check("m_tag_free", tag_write_enable_n, 1);
        if (j == 3) check("e_tag_upd", tag_write_enable_n, 0);
        if (j == 4) check("own_first", own_done, 1);
        if (j == 5) check("fill_first", fill_done, 1);
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    check("watchdog", 0, 1);
    finish_test();
  end

  // lines 0-2 modified, 3 exclusive, 4 shared, 5 miss with a dirty victim, 6 loads only
  initial begin
    {resetn, div3_select, sram_test, load_valid, store_valid} = 5'h00;
    load_req  = '0;
    store_req = '0;
    for (int i = 0; i < 7; i++) begin
      adr[i]   = PA_W'(256 + 64 * i);
      ref_d[i] = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      i_ecache_sram_model.dmem[adr[i][21:4]] = ref_d[i];
      i_ecache_sram_model.tmem[adr[i][21:6]] = '{i == 5 ? ~adr[i][21:3] : adr[i][21:3],
        i == 3 ? ST_EXCLUSIVE : i == 4 ? ST_SHARED : ST_MODIFIED};
    end
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 3; i++) load(i);
    for (int i = 0; i < 6; i++) store(i);
    load(6);
    load_valid <= 1'b0;
    drain();
    for (int i = 0; i < 7; i++) load(i);
    load_valid <= 1'b0;
    drain();
    check("e_now_m", i_ecache_sram_model.tmem[adr[3][21:6]].state, ST_MODIFIED);
    check("overlap", n_ovl > 0, 1);
    sysclk(1'b0);
    sysclk(1'b1);
    resetn    <= 1'b0;
    sram_test <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("rst_pins", {tag_oe, data_oe, byte_write_enable_n, data_write_enable_n},
      {2'b00, 17'h1_ffff});
    finish_test();
  end
endmodule
